// ===== shared/hmdp_pkg.sv
// Constants and carriers for the host memory port.
// Assumes one core clock; host pins arrive unsynchronised.
package hmdp_pkg;
  // ==========================================================
  // Core-side register map (data space)
  localparam logic [13:0] HMDP_OVERLAY_ADDR = 14'h3FE0;
  localparam logic [13:0] HMDP_CONFIG_ADDR  = 14'h3FE7;
  localparam logic [13:0] HMDP_ADDRCTL_ADDR = 14'h3FE1;
  localparam logic [13:0] HMDP_CTRL_LOW     = 14'h3FE0;
  // ==========================================================
  // Control word fields
  localparam int HMDP_OVL_FLAG_BIT  = 15;
  localparam int HMDP_SPACE_BIT     = 14;
  localparam int HMDP_ADDR_W        = 14;
  localparam int HMDP_OVL_W         = 8;
  localparam int HMDP_SHORT_RD_BIT  = 14;
  localparam logic [6:0] HMDP_OVL_GAP_ZERO = 7'h00;
  // ==========================================================
  // Legal overlay values on the overlay-capable variant
  localparam logic [7:0] HMDP_OVL_0 = 8'h00;
  localparam logic [7:0] HMDP_OVL_4 = 8'h04;
  localparam logic [7:0] HMDP_OVL_5 = 8'h05;
  // Boot mode strap: C,B,A = 1,0,1
  localparam logic [2:0] HMDP_BOOT_MODE = 3'h5;
  // ==========================================================
  // Reset values
  localparam logic [15:0] HMDP_CFG_RESET  = 16'h0000;
  localparam logic [15:0] HMDP_OVL_RESET  = 16'h0000;
  localparam logic [14:0] HMDP_ADDR_RESET = 15'h0000;

  typedef enum logic [1:0] {
    HMDP_IDLE, HMDP_SYNC, HMDP_MEM, HMDP_DONE
  } hmdp_state_t;

  typedef struct packed {
    logic        space_pm;
    logic [13:0] addr;
  } hmdp_addr_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        space_pm;
    logic [13:0] addr;
    logic [23:0] wdata;
  } hmdp_mem_req_t;

  typedef struct packed {
    logic [2:0]  sel_q1;
    logic [2:0]  sel_q2;
    logic [2:0]  sel_q3;
    hmdp_state_t state;
    logic        is_write;
    logic        half;
    hmdp_addr_t  ptr;
    logic [7:0]  ovl_data;
    logic [7:0]  ovl_prog;
    logic [15:0] cfg;
    logic [7:0]  lo_hold;
    logic [15:0] rdata;
    logic [7:0]  rd_hi;
    logic        boot_hold;
    logic [2:0]  mode_cap;
    logic        mode_done;
    logic        ack;
    hmdp_mem_req_t mem;
    logic [15:0] core_rdata;
  } hmdp_state_bundle_t;
endpackage

// ===== hdl/hmdp_host_port.sv
// Host memory port: host reaches on-chip program/data memory.
// Assumes single-cycle memory answering in the same cycle as a request.
module hmdp_host_port
  import hmdp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        port_select_n,
  input  wire logic        address_latch_strobe,
  input  wire logic        host_read_strobe_n,
  input  wire logic        host_write_strobe_n,
  input  wire logic [15:0] host_addr_data_bus_in,
  output logic      [15:0] host_addr_data_bus_out,
  output logic             host_addr_data_bus_oe_n,
  output logic             host_acknowledge_n,
  input  wire logic [2:0]  mode_pins,
  output logic             core_hold,
  output logic             short_read_only,
  output logic [7:0]       data_overlay_select,
  output logic [7:0]       program_overlay_select,
  output hmdp_mem_req_t    mem_req,
  input  wire logic [23:0] mem_rdata,
  input  wire logic        core_wr,
  input  wire logic        core_rd,
  input  wire logic [13:0] core_addr,
  input  wire logic [15:0] core_wdata,
  output logic      [15:0] core_rdata
);
  // ==========================================================
  // Pin synchronisers: bit2 latch, bit1 read, bit0 write
  // Bus data is sampled only after strobes settle through sync,
  // so it needs no synchroniser of its own.
  hmdp_state_bundle_t s_reg;
  hmdp_state_bundle_t s_next;
  logic [2:0]         pins;
  logic               latch_pin;
  logic               read_pin;
  logic               write_pin;
  logic               host_sel;
  logic               latch_fall;
  logic               rd_fall;
  logic               wr_rise;
  logic               strobes_idle;
  logic               ovl_ok;
  logic               ovl_gap_ok;
  logic               core_ovl_ok;
  logic               ctrl_hit;
  logic               pm_first_wr;
  logic               pm_half_rd;
  logic [15:0]        bus;

  // ==========================================================
  // Overlay legality; other values would select absent banks
  function automatic logic ovl_legal(input logic [7:0] v);
    return (v == HMDP_OVL_0) || (v == HMDP_OVL_4)
        || (v == HMDP_OVL_5);
  endfunction

  // ==========================================================
  // Qualified pin levels, sampled by the first stage
  assign host_sel  = ~port_select_n;
  assign latch_pin = address_latch_strobe & host_sel;
  assign read_pin  = ~host_read_strobe_n & host_sel;
  assign write_pin = ~host_write_strobe_n & host_sel;
  assign pins      = {latch_pin, read_pin, write_pin};

  // ==========================================================
  // Edge detectors on the settled stages only
  assign latch_fall   = s_reg.sel_q3[2] & ~s_reg.sel_q2[2];
  assign rd_fall      = ~s_reg.sel_q3[1] & s_reg.sel_q2[1];
  assign wr_rise      = s_reg.sel_q3[0] & ~s_reg.sel_q2[0];
  assign strobes_idle = ~s_reg.sel_q2[1] & ~s_reg.sel_q2[0];

  // ==========================================================
  // Bus decode, valid once the strobe edge is seen
  assign bus         = host_addr_data_bus_in;
  assign ovl_ok      = ovl_legal(bus[7:0]);
  assign ovl_gap_ok  = (bus[14:8] == HMDP_OVL_GAP_ZERO);
  assign core_ovl_ok = ovl_legal(core_wdata[7:0])
                     & ovl_legal(core_wdata[15:8]);

  // ==========================================================
  // Pointer and half-word qualifiers
  assign ctrl_hit    = (s_reg.ptr.addr >= HMDP_CTRL_LOW);
  assign pm_first_wr = s_reg.is_write & s_reg.ptr.space_pm
                     & ~s_reg.half;
  // Set after the first read of a PM word, until its second read
  assign pm_half_rd  = ~s_reg.is_write & s_reg.ptr.space_pm
                     & s_reg.half;

  // ==========================================================
  // Next-state logic
  always_comb begin
    s_next = s_reg;
    s_next.mem.req = 1'b0;
    s_next.core_rdata = 16'h0000;

    // Three-stage shift; only stages two and three feed edges
    s_next.sel_q1 = pins;
    s_next.sel_q2 = s_reg.sel_q1;
    s_next.sel_q3 = s_reg.sel_q2;

    // Strap caught once, after reset release
    if (!s_reg.mode_done) begin
      s_next.mode_cap = mode_pins;
      s_next.mode_done = 1'b1;
      s_next.boot_hold = (mode_pins == HMDP_BOOT_MODE);
    end

    // Host transaction sequencer
    unique case (s_reg.state)
      HMDP_IDLE: begin
        s_next.ack = 1'b1;
        if (latch_fall) begin
          if (bus[HMDP_OVL_FLAG_BIT]) begin
            // Overlay ignored unless gap bits zero and value legal
            if (ovl_gap_ok && ovl_ok) begin
              s_next.ovl_data = bus[7:0];
              s_next.ovl_prog = bus[7:0];
            end
          end else begin
            s_next.ptr.space_pm = bus[HMDP_SPACE_BIT];
            s_next.ptr.addr = bus[HMDP_ADDR_W-1:0];
            s_next.half = 1'b0;
          end
        end else if (rd_fall || wr_rise) begin
          s_next.is_write = wr_rise;
          s_next.ack = 1'b0;
          s_next.state = HMDP_SYNC;
        end
      end

      HMDP_SYNC: begin
        // One cycle reserved for synchronisation
        s_next.state = HMDP_MEM;
        if (pm_first_wr) begin
          // PM write, first word: hold upper 16 bits, no access
          s_next.lo_hold = bus[7:0];
          s_next.rdata = bus;
          s_next.half = 1'b1;
          s_next.state = HMDP_DONE;
        end else if (pm_half_rd) begin
          // Low byte already on the bus; close the word here
          s_next.half = 1'b0;
          s_next.ptr.addr = s_reg.ptr.addr + 14'h0001;
          s_next.state = HMDP_DONE;
        end else begin
          s_next.mem.req = 1'b1;
          s_next.mem.we = s_reg.is_write;
          s_next.mem.space_pm = s_reg.ptr.space_pm;
          s_next.mem.addr = s_reg.ptr.addr;
          // Control block never written from the host side
          if (s_reg.is_write && !s_reg.ptr.space_pm && ctrl_hit) begin
            s_next.mem.req = 1'b0;
          end
          if (s_reg.ptr.space_pm) begin
            s_next.mem.wdata = {s_reg.rdata, bus[7:0]};
          end else begin
            s_next.mem.wdata = {8'h00, bus};
          end
        end
      end

      HMDP_MEM: begin
        if (!s_reg.is_write) begin
          if (s_reg.ptr.space_pm) begin
            s_next.rdata = mem_rdata[23:8];
            s_next.rd_hi = mem_rdata[7:0];
            s_next.half = 1'b1;
          end else begin
            s_next.rdata = mem_rdata[15:0];
            s_next.ptr.addr = s_reg.ptr.addr + 14'h0001;
          end
        end else begin
          s_next.half = 1'b0;
          s_next.ptr.addr = s_reg.ptr.addr + 14'h0001;
          if (s_reg.ptr.space_pm && s_reg.ptr.addr == 14'h0000) begin
            s_next.boot_hold = 1'b0;
          end
        end
        s_next.state = HMDP_DONE;
      end

      HMDP_DONE: begin
        // Wait for strobe release before acknowledging again
        if (strobes_idle) begin
          s_next.ack = 1'b1;
          s_next.state = HMDP_IDLE;
          // First PM read released: low byte goes out next
          if (pm_half_rd) begin
            s_next.rdata = {8'h00, s_reg.rd_hi};
          end
        end
      end
    endcase

    // Core-side register writes; pointer only while port idle
    if (core_wr) begin
      unique case (core_addr)
        HMDP_OVERLAY_ADDR: begin
          if (core_ovl_ok) begin
            s_next.ovl_data = core_wdata[7:0];
            s_next.ovl_prog = core_wdata[15:8];
          end
        end
        HMDP_CONFIG_ADDR: s_next.cfg = core_wdata;
        HMDP_ADDRCTL_ADDR: begin
          if (s_reg.state == HMDP_IDLE && !latch_fall) begin
            s_next.ptr.space_pm = core_wdata[HMDP_SPACE_BIT];
            s_next.ptr.addr = core_wdata[HMDP_ADDR_W-1:0];
            s_next.half = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Core-side register reads; address control reads as zero
    if (core_rd) begin
      unique case (core_addr)
        HMDP_OVERLAY_ADDR: begin
          s_next.core_rdata = {s_reg.ovl_prog, s_reg.ovl_data};
        end
        HMDP_CONFIG_ADDR: s_next.core_rdata = s_reg.cfg;
        default: s_next.core_rdata = 16'h0000;
      endcase
    end
  end

  // ==========================================================
  // State register; idle pin levels are zero, so no false edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_reg.sel_q1     <= '0;
      s_reg.sel_q2     <= '0;
      s_reg.sel_q3     <= '0;
      s_reg.state      <= HMDP_IDLE;
      s_reg.is_write   <= 1'b0;
      s_reg.half       <= 1'b0;
      s_reg.ptr        <= HMDP_ADDR_RESET;
      s_reg.ovl_data   <= HMDP_OVL_RESET[7:0];
      s_reg.ovl_prog   <= HMDP_OVL_RESET[15:8];
      s_reg.cfg        <= HMDP_CFG_RESET;
      s_reg.lo_hold    <= '0;
      s_reg.rdata      <= '0;
      s_reg.rd_hi      <= '0;
      s_reg.boot_hold  <= 1'b0;
      s_reg.mode_cap   <= '0;
      s_reg.mode_done  <= 1'b0;
      s_reg.ack        <= 1'b0;
      s_reg.mem        <= '0;
      s_reg.core_rdata <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Host-side outputs; host reads rdata: memory data, or the held first word of a PM write
  assign host_addr_data_bus_out  = s_reg.rdata;
  assign host_addr_data_bus_oe_n = ~read_pin;
  // Acknowledge is active low; ready state drives it low
  assign host_acknowledge_n      = ~s_reg.ack;

  // ==========================================================
  // Core-side outputs
  assign core_hold              = s_reg.boot_hold | ~s_reg.mode_done;
  assign short_read_only        = s_reg.cfg[HMDP_SHORT_RD_BIT];
  assign data_overlay_select    = s_reg.ovl_data;
  assign program_overlay_select = s_reg.ovl_prog;
  assign mem_req                = s_reg.mem;
  assign core_rdata             = s_reg.core_rdata;
endmodule

// ===== dv/hmdp_mem_model.sv
// On-chip memory as seen by the host port.
// Assumes one-cycle req pulses; answers in the same cycle.
module hmdp_mem_model
  import hmdp_pkg::*;
(
  input  wire logic          clk,
  input  wire hmdp_mem_req_t mem_req,
  output logic [23:0]        mem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [23:0] pm [0:16383];
  logic [23:0] dm [0:16383];
  logic [23:0] stale_reg;
  initial begin
    pm = '{default: 24'h000000};
    dm = '{default: 24'h000000};
    stale_reg = 24'h000000;
  end
  // ==========================================
  // Writes land at the edge that ends the request cycle
  always @(posedge clk) begin
    if (mem_req.req && mem_req.we) begin
      if (mem_req.space_pm) pm[mem_req.addr] <= mem_req.wdata;
      else dm[mem_req.addr] <= mem_req.wdata;
    end
    stale_reg <= ~stale_reg;
  end
  // Read answer stands in the request cycle; port takes it at its end
  always_comb begin
    if (mem_req.req && !mem_req.we) begin
      mem_rdata = mem_req.space_pm ? pm[mem_req.addr]
                                   : dm[mem_req.addr];
    end else begin
      mem_rdata = stale_reg; // Stale data must not look valid
    end
  end
endmodule

// ===== dv/hmdp_host_port_properties.sv
// Pin-level assertions for the host memory port.
// Bound to hmdp_host_port; one core clock domain.
module hmdp_checker
  import hmdp_pkg::*;
(
  input wire logic          clk,
  input wire logic          reset,
  input wire logic          port_select_n,
  input wire logic          host_read_strobe_n,
  input wire logic          host_addr_data_bus_oe_n,
  input wire logic          host_acknowledge_n,
  input wire logic [2:0]    mode_pins,
  input wire logic          core_hold,
  input wire logic          short_read_only,
  input wire logic [7:0]    data_overlay_select,
  input wire logic [7:0]    program_overlay_select,
  input wire hmdp_mem_req_t mem_req,
  input wire logic          core_wr,
  input wire logic [13:0]   core_addr,
  input wire logic [15:0]   core_wdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic boot_wr_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) boot_wr_reg <= 1'b0;
    else if (mem_req.req && mem_req.we && mem_req.space_pm
             && mem_req.addr == 14'h0000) boot_wr_reg <= 1'b1;
  end
  // ==========================================
  // Properties
  AST_REQ_PULSE: assert property (
    mem_req.req |=> !mem_req.req)
    else $error("memory request wider than one cycle");
  AST_ACK_BUSY: assert property (
    mem_req.req |-> host_acknowledge_n)
    else $error("ready shown during memory cycle");
  AST_NO_CTRL_WR: assert property (
    mem_req.req && mem_req.we && !mem_req.space_pm
    |-> mem_req.addr < HMDP_CTRL_LOW)
    else $error("host write reached control area");
  AST_READ_OE: assert property (
    host_addr_data_bus_oe_n == (port_select_n | host_read_strobe_n))
    else $error("bus drive enable wrong");
  AST_SHORT_RD: assert property (
    core_wr && core_addr == HMDP_CONFIG_ADDR
    && core_wdata[HMDP_SHORT_RD_BIT] |-> ##[1:2] short_read_only)
    else $error("short read mode not set");
  AST_OVL_CORE: assert property (
    core_wr && core_addr == HMDP_OVERLAY_ADDR && core_wdata == 16'h0504
    |-> ##[1:2] (data_overlay_select == 8'h04
                 && program_overlay_select == 8'h05))
    else $error("overlay write not taken");
  AST_BOOT_HOLD: assert property (
    mode_pins == HMDP_BOOT_MODE && !boot_wr_reg |-> core_hold)
    else $error("core released before word zero");
  AST_ACK_DROP: assert property (
    $fell(host_read_strobe_n) && !port_select_n && !host_acknowledge_n
    |-> ##[1:6] host_acknowledge_n)
    else $error("busy not shown after read");
endmodule
bind hmdp_host_port hmdp_checker u_chk (.*);

// ===== dv/hmdp_host_port_bench.sv
// Host-side bench for the host memory port.
// Assumes hmdp_mem_model as on-chip memory.
`define CHK(a, b) begin \
  checks++; \
  if ((a) !== (b)) begin \
    err_total++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, b); \
  end \
end
module hmdp_host_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import hmdp_pkg::*;
  logic clk = 0, reset = 1, sel_n = 1, las = 0, rd_n = 1, wr_n = 1;
  logic [15:0] bus_in = 16'h0000, bus_out, core_wdata = 16'h0000;
  logic [15:0] core_rdata;
  logic oe_n, ack_n, core_hold, sro, core_wr = 0, core_rd = 0;
  logic [2:0] mode_pins = HMDP_BOOT_MODE;
  logic [7:0] dovl, povl;
  logic [13:0] core_addr = 14'h0000;
  logic [23:0] mem_rdata;
  hmdp_mem_req_t mem_req;
  int err_total = 0, checks = 0;
  localparam logic [15:0] PMW [4] = '{16'hABCD, 16'h00EF,
                                      16'h1234, 16'h0056};
  always #2 clk = ~clk;
  hmdp_host_port dut (.clk(clk), .reset(reset), .port_select_n(sel_n),
    .address_latch_strobe(las), .host_read_strobe_n(rd_n),
    .host_write_strobe_n(wr_n), .host_addr_data_bus_in(bus_in),
    .host_addr_data_bus_out(bus_out), .host_addr_data_bus_oe_n(oe_n),
    .host_acknowledge_n(ack_n), .mode_pins(mode_pins),
    .core_hold(core_hold), .short_read_only(sro),
    .data_overlay_select(dovl), .program_overlay_select(povl),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .core_wr(core_wr),
    .core_rd(core_rd), .core_addr(core_addr), .core_wdata(core_wdata),
    .core_rdata(core_rdata));
  hmdp_mem_model u_mem (.clk(clk), .mem_req(mem_req),
    .mem_rdata(mem_rdata));
  // ==========================================
  // Host and core access tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_ack;
    int n;
    n = 0;
    while (ack_n !== 1'b0 && n < 100) begin
      cyc(1);
      n++;
    end
    if (ack_n !== 1'b0) begin
      err_total++;
      $display("mismatch t=%0t acknowledge never returned", $time);
      final_report;
    end
  endtask
  task automatic host_latch(input logic [15:0] w);
    wait_ack;
    sel_n = 0;
    las = 1;
    bus_in = w;
    cyc(2);
    las = 0;
    cyc(5);
    sel_n = 1;
    bus_in = ~w;
    cyc(1);
  endtask
  task automatic host_wr(input logic [15:0] w);
    wait_ack;
    sel_n = 0;
    wr_n = 0;
    bus_in = w;
    cyc(2);
    wr_n = 1;
    cyc(5);
    sel_n = 1;
    bus_in = ~w;
    cyc(1);
  endtask
  task automatic host_rd(input logic [15:0] e);
    wait_ack;
    sel_n = 0;
    rd_n = 0;
    cyc(8);
    `CHK(oe_n, 1'b0)
    `CHK(bus_out, e)
    rd_n = 1;
    cyc(1);
    sel_n = 1;
    cyc(1);
  endtask
  task automatic core_write(input logic [13:0] a, input logic [15:0] d);
    core_addr = a;
    core_wdata = d;
    core_wr = 1;
    cyc(1);
    core_wr = 0;
    cyc(1);
  endtask
  task automatic core_read(input logic [13:0] a, input logic [15:0] e);
    core_addr = a;
    core_rd = 1;
    cyc(1);
    core_rd = 0;
    `CHK(core_rdata, e)
    cyc(1);
  endtask
  task automatic final_report;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================
  // Tests
  initial begin
    cyc(5);
    reset = 0;
    cyc(6);
    `CHK(core_hold, 1'b1)
    host_latch(16'h4000);
    for (int i = 0; i < 4; i++) host_wr(PMW[i]);
    cyc(3);
    `CHK(core_hold, 1'b0)
    `CHK(u_mem.pm[0], 24'hABCDEF)
    `CHK(u_mem.pm[1], 24'h123456)
    host_latch(16'h4000);
    for (int i = 0; i < 4; i++) host_rd(PMW[i]);
    host_latch(16'h0010);
    `CHK(bus_out, 16'h0056)
    host_wr(16'hBEEF);
    host_wr(16'h0BAD);
    host_latch(16'h0010);
    host_rd(16'hBEEF);
    host_rd(16'h0BAD);
    host_latch(16'h3FE0);
    host_wr(16'hFFFF);
    `CHK(u_mem.dm[14'h3FE0], 24'h000000)
    core_read(HMDP_OVERLAY_ADDR, 16'h0000);
    host_latch(16'h8004);
    `CHK(dovl, 8'h04)
    host_latch(16'h8003);
    host_latch(16'h8105);
    `CHK(povl, 8'h04)
    core_write(HMDP_OVERLAY_ADDR, 16'h0504);
    core_read(HMDP_OVERLAY_ADDR, 16'h0504);
    core_write(HMDP_CONFIG_ADDR, 16'h4000);
    `CHK(sro, 1'b1)
    core_write(HMDP_ADDRCTL_ADDR, 16'h4000);
    host_rd(16'hABCD);
    final_report;
  end
  initial begin
    #20000; err_total++; final_report;
  end
endmodule
